// ==== uipc_pkg.sv ====
// uipc_pkg: shared types and constants for the multipurpose pin configuration block
package uipc_pkg;

    // ------------------------------------------------------------
    // pin function encodings
    // ------------------------------------------------------------
    // functions of multipurpose pin seven
    typedef enum logic [1:0] {
        UIPC_P7_GPIO  = 2'h0,
        UIPC_P7_POWER_ENABLE_READY_LOW = 2'h1,
        UIPC_P7_TXLMP = 2'h2,
        UIPC_P7_SUSP  = 2'h3
    } uipc_p7_func_t;

    // functions of multipurpose pin zero; code 3 behaves as gpio
    typedef enum logic [1:0] {
        UIPC_P0_GPIO  = 2'h0,
        UIPC_P0_TXLMP = 2'h1,
        UIPC_P0_TXACT = 2'h2,
        UIPC_P0_RSVD  = 2'h3
    } uipc_p0_func_t;

    // functions of multipurpose pin twelve
    typedef enum logic [1:0] {
        UIPC_P12_GPIO  = 2'h0,
        UIPC_P12_POWER_ENABLE_READY_LOW = 2'h1,
        UIPC_P12_RXLMP = 2'h2,
        UIPC_P12_BCD   = 2'h3
    } uipc_p12_func_t;

    // trigger type of the hid target interrupt input
    typedef enum logic [1:0] {
        UIPC_TRIG_RISE = 2'h0,
        UIPC_TRIG_FALL = 2'h1,
        UIPC_TRIG_HIGH = 2'h2,
        UIPC_TRIG_LOW  = 2'h3
    } uipc_trig_t;

    // ------------------------------------------------------------
    // configuration records
    // ------------------------------------------------------------
    // parameter set held by the fuses
    typedef struct packed {
        logic [15:0] vid;         // usb vendor identifier
        logic [15:0] pid;         // usb product identifier
        logic [1:0] uart_drive;   // 0..3 = 4/8/12/16 mA
        logic [1:0] gpio_drive;   // 0..3 = 4/8/12/16 mA
        uipc_p7_func_t p7_func;
        uipc_p0_func_t p0_func;
        uipc_p12_func_t p12_func;
        uipc_trig_t irq_trig;
        logic [6:0] hid_addr;     // zero means no hid target
        logic bcd_pol;            // 1 = active high
    } uipc_cfg_t;

    // eeprom set: everything in the fuses plus suspend pin levels and the pin eight interrupt enable
    typedef struct packed {
        uipc_cfg_t base;
        logic [2:0] susp_level;   // levels of gpio pins while suspended {p12,p7,p0}
        logic irq_pin_en;         // pin eight used as hid interrupt input
    } uipc_eep_cfg_t;

    // ------------------------------------------------------------
    // values after reset (built-in defaults)
    // ------------------------------------------------------------
    localparam logic [15:0] UIPC_DEF_VID = 16'h1234; // arbitrary value
    localparam logic [15:0] UIPC_DEF_PID = 16'h5678; // arbitrary value
    localparam uipc_cfg_t UIPC_DEF_CFG = '{vid: UIPC_DEF_VID, pid: UIPC_DEF_PID,
        uart_drive: 2'h0, gpio_drive: 2'h0, p7_func: UIPC_P7_SUSP, p0_func: UIPC_P0_TXACT,
        p12_func: UIPC_P12_BCD, irq_trig: UIPC_TRIG_RISE, hid_addr: 7'h00, bcd_pol: 1'b1};
    localparam logic [2:0] UIPC_DEF_SUSP_LEVEL = 3'h0;
    localparam logic UIPC_DEF_IRQ_PIN_EN = 1'b1;

    // lamp toggle divider, cycles of the 25 MHz clock
    localparam int UIPC_CLK_HZ = 25000000;
    localparam int UIPC_LAMP_HZ = 10;
    localparam int UIPC_LAMP_DIV = UIPC_CLK_HZ / (2 * UIPC_LAMP_HZ);

endpackage : uipc_pkg

// ==== uipc_pin_config.sv ====
// uipc_pin_config: config loading and alternate functions of the multipurpose pins
`timescale 1ns/1ps
module uipc_pin_config
    import uipc_pkg::*;
#(
    parameter int LAMP_DIV = UIPC_LAMP_DIV
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire uipc_cfg_t i_fuse_cfg,
    input wire logic i_fuse_programmed,
    input wire logic i_fuse_enabled,
    input wire logic i_eep_present,
    input wire logic i_eep_valid,
    input wire uipc_eep_cfg_t i_eep_cfg,
    input wire logic i_i2c_idle,
    input wire logic i_i2c_eep_req,
    input wire logic i_i2c_hid_req,
    input wire logic i_usb_suspend,
    input wire logic i_usb_configured,
    input wire logic i_bit_tick,
    input wire logic i_tx_req,
    input wire logic i_tx_last_bit,
    input wire logic i_tx_busy,
    input wire logic i_rx_busy,
    input wire logic i_bcd_detect,
    input wire logic [2:0] i_gpio_out,
    input wire logic [2:0] i_gpio_oe,
    input wire logic i_multipurpose_pin_eight,
    output logic o_multipurpose_pin_zero,
    output logic o_multipurpose_pin_zero_oe,
    output logic o_multipurpose_pin_seven,
    output logic o_multipurpose_pin_seven_oe,
    output logic o_multipurpose_pin_twelve,
    output logic o_multipurpose_pin_twelve_oe,
    output logic o_tx_start,
    output logic o_hid_target_irq_in,
    output logic o_i2c_grant_eep,
    output logic o_i2c_grant_hid,
    output logic o_load_done,
    output uipc_eep_cfg_t o_cfg
);

    // ------------------------------------------------------------
    // configuration loader
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        LD_DEF  = 4'b0001,
        LD_FUSE = 4'b0010,
        LD_EEP  = 4'b0100,
        LD_DONE = 4'b1000
    } uipc_ld_state_t;

    uipc_ld_state_t ld_state; // loader step
    uipc_eep_cfg_t cfg;       // working configuration
    uipc_eep_cfg_t next_cfg;  // value loaded at this edge

    // choose the source for each loader step
    always_comb begin
        next_cfg = cfg;
        unique case (ld_state)
            LD_DEF: begin
                next_cfg = '{base: UIPC_DEF_CFG, susp_level: UIPC_DEF_SUSP_LEVEL,
                             irq_pin_en: UIPC_DEF_IRQ_PIN_EN};
            end
            LD_FUSE: begin
                if (i_fuse_programmed && i_fuse_enabled) begin
                    next_cfg.base = i_fuse_cfg;
                end
            end
            LD_EEP: begin
                if (i_eep_present && i_eep_valid) begin
                    next_cfg = i_eep_cfg;
                end
            end
            LD_DONE: begin
                next_cfg = cfg;
            end
            default: begin
                next_cfg = cfg;
            end
        endcase
    end

    // loader sequence; eeprom step waits for valid or absence
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            ld_state <= LD_DEF;
        end else begin
            unique case (ld_state)
                LD_DEF: begin
                    ld_state <= LD_FUSE;
                end
                LD_FUSE: begin
                    ld_state <= LD_EEP;
                end
                LD_EEP: begin
                    if (!i_eep_present || i_eep_valid) begin
                        ld_state <= LD_DONE;
                    end
                end
                LD_DONE: begin
                    ld_state <= LD_DONE;
                end
                default: begin
                    ld_state <= LD_DEF;
                end
            endcase
        end
    end

    // working configuration; frozen once loading finishes
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            cfg <= '{base: UIPC_DEF_CFG, susp_level: UIPC_DEF_SUSP_LEVEL, irq_pin_en: UIPC_DEF_IRQ_PIN_EN};
        end else if (ld_state != LD_DONE) begin
            cfg <= next_cfg;
        end
    end

    // published configuration and done flag
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_cfg <= '{base: UIPC_DEF_CFG, susp_level: UIPC_DEF_SUSP_LEVEL, irq_pin_en: UIPC_DEF_IRQ_PIN_EN};
            o_load_done <= 1'b0;
        end else begin
            o_cfg <= cfg;
            o_load_done <= (ld_state == LD_DONE);
        end
    end

    uipc_cfg_t act; // functions seen by the pins
    assign act = o_load_done ? o_cfg.base : UIPC_DEF_CFG;

    // ------------------------------------------------------------
    // shared i2c bus arbitration
    // ------------------------------------------------------------
    // grants only change while the bus is idle, so a transfer is never cut
    logic last_eep; // eeprom held the bus last, for fairness
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_i2c_grant_eep <= 1'b0;
            o_i2c_grant_hid <= 1'b0;
            last_eep <= 1'b0;
        end else if (i_i2c_idle) begin
            if (ld_state == LD_EEP) begin
                o_i2c_grant_eep <= 1'b1;
                o_i2c_grant_hid <= 1'b0;
            end else if (i_i2c_eep_req && (!i_i2c_hid_req || !last_eep)) begin
                o_i2c_grant_eep <= 1'b1;
                o_i2c_grant_hid <= 1'b0;
                last_eep <= 1'b1;
            end else if (i_i2c_hid_req && o_load_done) begin
                o_i2c_grant_eep <= 1'b0;
                o_i2c_grant_hid <= 1'b1;
                last_eep <= 1'b0;
            end else begin
                o_i2c_grant_eep <= 1'b0;
                o_i2c_grant_hid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // hid target interrupt input
    // ------------------------------------------------------------
    logic irq_prev; // last sample of pin eight
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            irq_prev <= 1'b0;
            o_hid_target_irq_in <= 1'b0;
        end else begin
            irq_prev <= i_multipurpose_pin_eight;
            if (!o_cfg.irq_pin_en || act.hid_addr == 7'h00) begin
                o_hid_target_irq_in <= 1'b0;
            end else begin
                unique case (act.irq_trig)
                    UIPC_TRIG_RISE: o_hid_target_irq_in <= i_multipurpose_pin_eight && !irq_prev;
                    UIPC_TRIG_FALL: o_hid_target_irq_in <= !i_multipurpose_pin_eight && irq_prev;
                    UIPC_TRIG_HIGH: o_hid_target_irq_in <= i_multipurpose_pin_eight;
                    UIPC_TRIG_LOW: o_hid_target_irq_in <= !i_multipurpose_pin_eight;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // transmit-active framing
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        TX_IDLE = 3'b001,
        TX_LEAD = 3'b010,
        TX_SEND = 3'b100
    } uipc_tx_state_t;

    uipc_tx_state_t tx_state; // framing step
    logic tx_active;          // transmit-active level

    // the lead is timed by the uart bit ticks, so it lasts from one i_bit_tick to the next
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            tx_state <= TX_IDLE;
            o_tx_start <= 1'b0;
        end else begin
            o_tx_start <= 1'b0;
            unique case (tx_state)
                // lead opens on a bit boundary, so it spans a whole bit
                TX_IDLE: begin
                    if (i_tx_req && i_bit_tick) begin
                        tx_state <= TX_LEAD;
                    end
                end
                TX_LEAD: begin
                    if (i_bit_tick) begin
                        tx_state <= TX_SEND;
                        o_tx_start <= 1'b1;
                    end
                end
                TX_SEND: begin
                    if (i_bit_tick && i_tx_last_bit) begin
                        tx_state <= TX_IDLE;
                    end
                end
            endcase
        end
    end
    assign tx_active = (tx_state != TX_IDLE);

    // ------------------------------------------------------------
    // activity lamps
    // ------------------------------------------------------------
    logic [31:0] lamp_cnt; // divider for the toggle rate
    logic lamp_tick;       // one-cycle enable at toggle rate
    logic send_activity_lamp;
    logic receive_activity_lamp;

    // free-running divider; lamps only toggle while busy
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            lamp_cnt <= 32'h0;
            lamp_tick <= 1'b0;
        end else begin
            lamp_tick <= (lamp_cnt == 32'(LAMP_DIV - 1));
            lamp_cnt <= (lamp_cnt == 32'(LAMP_DIV - 1)) ? 32'h0 : lamp_cnt + 32'h1;
        end
    end

    // lamps toggle on activity, rest high (off)
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            send_activity_lamp <= 1'b1;
            receive_activity_lamp <= 1'b1;
        end else begin
            if (!i_tx_busy) begin
                send_activity_lamp <= 1'b1;
            end else if (lamp_tick) begin
                send_activity_lamp <= !send_activity_lamp;
            end
            if (!i_rx_busy) begin
                receive_activity_lamp <= 1'b1;
            end else if (lamp_tick) begin
                receive_activity_lamp <= !receive_activity_lamp;
            end
        end
    end

    // ------------------------------------------------------------
    // pin output multiplexers
    // ------------------------------------------------------------
    logic suspend_indicator_n;   // low while suspended
    logic power_enable_ready_n;  // low when configured and awake
    logic bcd_level;             // charger detect with polarity
    assign suspend_indicator_n = !i_usb_suspend;
    assign power_enable_ready_n = !(o_load_done && i_usb_configured && !i_usb_suspend);
    assign bcd_level = act.bcd_pol ? i_bcd_detect : !i_bcd_detect;

    // gpio pin value; suspend levels from the eeprom take over while suspended
    function automatic logic [1:0] gpio_drive(input logic idx_out, input logic idx_oe, input logic susp_lvl);
        gpio_drive = i_usb_suspend ? {susp_lvl, 1'b1} : {idx_out, idx_oe};
    endfunction

    logic [1:0] p0_next;  // {level, enable}
    logic [1:0] p7_next;
    logic [1:0] p12_next;

    always_comb begin
        unique case (act.p0_func)
            UIPC_P0_TXACT: p0_next = {tx_active, 1'b1};
            UIPC_P0_TXLMP: p0_next = {send_activity_lamp, 1'b1};
            UIPC_P0_GPIO, UIPC_P0_RSVD: p0_next = gpio_drive(i_gpio_out[0], i_gpio_oe[0], o_cfg.susp_level[0]);
        endcase
        unique case (act.p7_func)
            UIPC_P7_SUSP: p7_next = {suspend_indicator_n, 1'b1};
            UIPC_P7_POWER_ENABLE_READY_LOW: p7_next = {power_enable_ready_n, 1'b1};
            UIPC_P7_TXLMP: p7_next = {send_activity_lamp, 1'b1};
            UIPC_P7_GPIO: p7_next = gpio_drive(i_gpio_out[1], i_gpio_oe[1], o_cfg.susp_level[1]);
        endcase
        unique case (act.p12_func)
            UIPC_P12_POWER_ENABLE_READY_LOW: p12_next = {power_enable_ready_n, 1'b1};
            UIPC_P12_RXLMP: p12_next = {receive_activity_lamp, 1'b1};
            UIPC_P12_BCD: p12_next = {bcd_level, 1'b1};
            UIPC_P12_GPIO: p12_next = gpio_drive(i_gpio_out[2], i_gpio_oe[2], o_cfg.susp_level[2]);
        endcase
    end

    // registered pins; one cycle late against the internal sources
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_multipurpose_pin_zero <= 1'b0;
            o_multipurpose_pin_zero_oe <= 1'b0;
            o_multipurpose_pin_seven <= 1'b1;
            o_multipurpose_pin_seven_oe <= 1'b0;
            o_multipurpose_pin_twelve <= 1'b0;
            o_multipurpose_pin_twelve_oe <= 1'b0;
        end else begin
            {o_multipurpose_pin_zero, o_multipurpose_pin_zero_oe} <= p0_next;
            {o_multipurpose_pin_seven, o_multipurpose_pin_seven_oe} <= p7_next;
            {o_multipurpose_pin_twelve, o_multipurpose_pin_twelve_oe} <= p12_next;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    sequence lead_tick_s;
        tx_state == TX_LEAD && i_bit_tick;
    endsequence
    sequence start_pulse_s;
        o_tx_start && tx_active;
    endsequence

    lead_start_a: assert property (lead_tick_s |=> start_pulse_s)
        else $error("start pulse missing after lead bit");
    stop_drop_a: assert property (tx_state == TX_SEND && i_bit_tick && i_tx_last_bit |=> !tx_active)
        else $error("transmit-active not dropped at stop");
    txact_pin_a: assert property (act.p0_func == UIPC_P0_TXACT |=> o_multipurpose_pin_zero == $past(tx_active))
        else $error("pin zero does not follow transmit-active");
    susp_pin_a: assert property (act.p7_func == UIPC_P7_SUSP |=> o_multipurpose_pin_seven == !$past(i_usb_suspend))
        else $error("suspend indicator wrong");
    ready_low_a: assert property (o_load_done && i_usb_configured && !i_usb_suspend |-> !power_enable_ready_n)
        else $error("ready indicator not low when ready");
    defaults_hold_a: assert property (!o_load_done |-> act == UIPC_DEF_CFG)
        else $error("pin functions left defaults before load");
    cfg_frozen_a: assert property (o_load_done |=> $stable(o_cfg))
        else $error("configuration changed after load");
    eep_wins_a: assert property (ld_state == LD_EEP && i_eep_present && i_eep_valid |=> ##1 o_cfg == $past(i_eep_cfg, 2))
        else $error("eeprom data did not override");
    fuse_load_a: assert property (ld_state == LD_FUSE && i_fuse_programmed && i_fuse_enabled |=> cfg.base == $past(i_fuse_cfg))
        else $error("fuse data not loaded");
    rise_irq_a: assert property (o_cfg.irq_pin_en && act.hid_addr != 7'h00 && act.irq_trig == UIPC_TRIG_RISE
        && i_multipurpose_pin_eight && !irq_prev |=> o_hid_target_irq_in)
        else $error("rising edge interrupt missed");
    one_grant_a: assert property (!(o_i2c_grant_eep && o_i2c_grant_hid))
        else $error("both i2c parties granted");

endmodule // uipc_pin_config

// ==== uipc_far_side.sv ====
// uipc_far_side: uart bit timer and line converter stand-in for the bench
`timescale 1ns/1ps
module uipc_far_side (
    input wire logic i_clk,
    input wire logic i_tx_start,
    input wire logic i_driver_enable,
    input wire logic i_line_rx,
    output logic o_bit_tick,
    output logic o_last_bit,
    output logic o_tx_busy,
    output logic o_rxd
);
    // ------------------------------------------------------------
    // bit timer and character progress
    // ------------------------------------------------------------
    int div = 0; // free running, so the lead phase varies per frame
    int idx = 0; // 0 start, 1..8 data, 9 stop
    initial begin
        o_bit_tick = 1'b0;
        o_tx_busy = 1'b0;
    end
    // changes land on the falling edge, well away from sampling
    always @(negedge i_clk) begin
        div <= (div == 7) ? 0 : div + 1;
        o_bit_tick <= (div == 6);
        if (i_tx_start) begin
            o_tx_busy <= 1'b1;
            idx <= 0;
        end
        else if (o_bit_tick && o_tx_busy) begin
            idx <= idx + 1;
            o_tx_busy <= (idx != 9);
        end
    end
    assign o_last_bit = o_tx_busy && (idx == 8);
    assign o_rxd = i_driver_enable | i_line_rx;
endmodule // uipc_far_side

// ==== uipc_pin_config_tb.sv ====
// uipc_pin_config_tb: self-checking bench for the pin configuration block
`timescale 1ns/1ps
module uipc_pin_config_tb;
    import uipc_pkg::*;
    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    logic i_clk = 1'b0, i_rst_b = 1'b0, i_fuse_programmed = 1'b0, i_fuse_enabled = 1'b0;
    logic i_eep_present = 1'b0, i_eep_valid = 1'b0, i_i2c_idle = 1'b1, i_i2c_eep_req = 1'b0;
    logic i_i2c_hid_req = 1'b0, i_usb_suspend = 1'b0, i_usb_configured = 1'b0, i_tx_req = 1'b0;
    logic i_rx_busy = 1'b0, i_bcd_detect = 1'b0, i_multipurpose_pin_eight = 1'b0, line_rx = 1'b0;
    logic [2:0] i_gpio_out = 3'h0, i_gpio_oe = 3'h0; // software gpio left idle
    uipc_cfg_t i_fuse_cfg = UIPC_DEF_CFG;
    uipc_eep_cfg_t i_eep_cfg = '0, o_cfg;
    logic i_bit_tick, i_tx_last_bit, i_tx_busy, rxd, o_tx_start, o_hid_target_irq_in;
    logic o_multipurpose_pin_zero, o_multipurpose_pin_zero_oe, o_multipurpose_pin_seven;
    logic o_multipurpose_pin_seven_oe, o_multipurpose_pin_twelve, o_multipurpose_pin_twelve_oe;
    logic o_i2c_grant_eep, o_i2c_grant_hid, o_load_done;
    int errors = 0, check_count = 0, seed = 32'h6470, cyc = 0;
    // short lamp divider keeps the run brief
    uipc_pin_config #(.LAMP_DIV(4)) uipc_pin_config_inst (.i_clk, .i_rst_b, .i_fuse_cfg, .i_fuse_programmed,
        .i_fuse_enabled, .i_eep_present, .i_eep_valid, .i_eep_cfg, .i_i2c_idle, .i_i2c_eep_req, .i_i2c_hid_req,
        .i_usb_suspend, .i_usb_configured, .i_bit_tick, .i_tx_req, .i_tx_last_bit, .i_tx_busy, .i_rx_busy,
        .i_bcd_detect, .i_gpio_out, .i_gpio_oe, .i_multipurpose_pin_eight, .o_multipurpose_pin_zero,
        .o_multipurpose_pin_zero_oe, .o_multipurpose_pin_seven, .o_multipurpose_pin_seven_oe,
        .o_multipurpose_pin_twelve, .o_multipurpose_pin_twelve_oe, .o_tx_start, .o_hid_target_irq_in,
        .o_i2c_grant_eep, .o_i2c_grant_hid, .o_load_done, .o_cfg);
    uipc_far_side uipc_far_side_inst (.i_clk, .i_tx_start(o_tx_start), .i_driver_enable(o_multipurpose_pin_zero),
        .i_line_rx(line_rx), .o_bit_tick(i_bit_tick), .o_last_bit(i_tx_last_bit), .o_tx_busy(i_tx_busy), .o_rxd(rxd));
    // ------------------------------------------------------------
    // clock, hang guard and reporting
    // ------------------------------------------------------------
    always #20 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            errors++;
            report_and_stop();
        end
    end
    task automatic chk(input string w, input logic [63:0] s, input logic [63:0] e);
        check_count++;
        if (s !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", w, e, s);
        end
    endtask
    task automatic report_and_stop;
        if (errors == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // reset for 16 cycles, then wait for the loader under a bound
    task automatic load(input logic fp, input logic fe, input logic ep);
        logic seen;
        seen = 1'b0;
        @(negedge i_clk);
        i_rst_b = 1'b0;
        {i_fuse_programmed, i_fuse_enabled, i_eep_present, i_eep_valid} = {fp, fe, ep, ep};
        repeat (16) @(negedge i_clk);
        chk("reset outputs", {o_load_done, o_multipurpose_pin_zero_oe, o_tx_start}, 3'h0);
        i_rst_b = 1'b1;
        for (int n = 0; n < 20 && o_load_done !== 1'b1; n++) begin
            @(negedge i_clk);
            seen |= o_i2c_grant_eep;
        end
        // the loader scans the bus in its eeprom step even when nothing answers
        chk("eeprom bus grant", seen, 1'b1);
    endtask
    // two characters back to back on the transmit-active pin
    task automatic tx_frames;
        int tr, tl, starts;
        logic prev;
        {tr, tl, starts, prev} = {32'h0, 32'h0, 32'h0, 1'b0};
        i_tx_req = 1'b1;
        for (int n = 0; n < 300; n++) begin
            @(negedge i_clk);
            chk("echo masked", rxd, line_rx | o_multipurpose_pin_zero);
            line_rx = 1'($random(seed));
            if (prev === 1'b0 && o_multipurpose_pin_zero === 1'b1)
                tr = n;
            else if (prev === 1'b1 && o_multipurpose_pin_zero === 1'b0)
                chk("drop at stop", n - tl, 1);
            if (o_tx_start === 1'b1) begin
                // eight-cycle bit; the pin is one register behind transmit-active, which rises with the lead
                chk("lead one bit", n - tr, 7);
                chk("active at start", {o_multipurpose_pin_zero, o_multipurpose_pin_zero_oe}, 2'h3);
                starts++;
                if (starts == 2) i_tx_req = 1'b0;
            end
            if (i_bit_tick && i_tx_last_bit) tl = n;
            prev = o_multipurpose_pin_zero;
        end
        chk("frames sent", starts, 2);
    endtask
    // power enable and both activity lamps
    task automatic lamps_power;
        int tog0, tog12, bz;
        logic a, b;
        for (int c = 0; c < 4; c++) begin
            {i_usb_configured, i_usb_suspend} = 2'(c);
            repeat (3) @(negedge i_clk);
            chk("power enable", o_multipurpose_pin_seven, c != 2);
        end
        chk("lamps idle", {o_multipurpose_pin_zero, o_multipurpose_pin_twelve}, 2'h3);
        {tog0, tog12, bz, i_tx_req, i_rx_busy} = {96'h0, 2'h3};
        for (int n = 0; n < 40; n++) begin
            {a, b} = {o_multipurpose_pin_zero, o_multipurpose_pin_twelve};
            @(negedge i_clk);
            if (o_tx_start === 1'b1) i_tx_req = 1'b0;
            bz += i_tx_busy;
            tog0 += (a !== o_multipurpose_pin_zero);
            tog12 += (b !== o_multipurpose_pin_twelve);
        end
        i_rx_busy = 1'b0;
        chk("rx lamp toggles", tog12 >= 9 && tog12 <= 10, 1'b1);
        chk("tx lamp toggles", tog0 >= bz / 4 - 1 && tog0 <= bz / 4 + 1, 1'b1);
        for (int n = 0; n < 120 && i_tx_busy; n++) @(negedge i_clk);
        repeat (3) @(negedge i_clk);
        chk("lamps idle again", {o_multipurpose_pin_zero, o_multipurpose_pin_twelve}, 2'h3);
    endtask
    // interrupt trigger and bus sharing against an integer model
    task automatic irq_bus(input int t);
        logic p1, p2, eg, hg, e, lh;
        // lh: hid held the bus last, as the arbiter assumes after reset
        {p1, p2, eg, hg, lh} = 5'h1;
        for (int n = 0; n < 60; n++) begin
            @(negedge i_clk);
            e = (t == 0) ? p1 & ~p2 : (t == 1) ? ~p1 & p2 : (t == 2) ? p1 : ~p1;
            chk("irq", o_hid_target_irq_in, e);
            chk("grants", {o_i2c_grant_eep, o_i2c_grant_hid}, {eg, hg});
            p2 = p1;
            p1 = 1'($random(seed));
            i_multipurpose_pin_eight = p1;
            {i_i2c_idle, i_i2c_eep_req, i_i2c_hid_req} = 3'($random(seed));
            if (i_i2c_idle) begin
                eg = i_i2c_eep_req & (~i_i2c_hid_req | lh);
                hg = ~eg & i_i2c_hid_req;
                lh = hg | (lh & ~eg);
            end
        end
        {i_i2c_idle, i_i2c_eep_req, i_i2c_hid_req, i_multipurpose_pin_eight} = 4'h8;
    endtask
    // ------------------------------------------------------------
    // main sequence: defaults, fuse refused, fuse, eeprom per trigger
    // ------------------------------------------------------------
    initial begin
        uipc_eep_cfg_t exp;
        logic [63:0] r;
        for (int k = 0; k < 7; k++) begin
            r = {$random(seed), $random(seed)};
            i_fuse_cfg = r[51:0];
            i_eep_cfg = r[63:8];
            if (k == 2) {i_fuse_cfg.p0_func, i_fuse_cfg.p7_func, i_fuse_cfg.p12_func} = 6'h16;
            i_eep_cfg.base.irq_trig = uipc_trig_t'(k % 4);
            i_eep_cfg.base.hid_addr[0] = 1'b1;
            i_eep_cfg.irq_pin_en = 1'b1;
            load(k > 0, k > 1, k > 2);
            exp = i_eep_cfg;
            if (k < 3) exp = '{(k == 2) ? i_fuse_cfg : UIPC_DEF_CFG, UIPC_DEF_SUSP_LEVEL, UIPC_DEF_IRQ_PIN_EN};
            repeat (2) @(negedge i_clk);
            chk("active cfg", o_cfg, exp);
            {i_fuse_cfg, i_eep_cfg} = ~{i_fuse_cfg, i_eep_cfg};
            repeat (3) @(negedge i_clk);
            chk("cfg held", o_cfg, exp);
            for (int c = 0; c < 2 && k == 0; c++) begin
                {i_usb_suspend, i_bcd_detect} = {1'(c), 1'(c)};
                repeat (3) @(negedge i_clk);
                chk("suspend pin", {o_multipurpose_pin_seven, o_multipurpose_pin_seven_oe}, {c == 0, 1'b1});
                chk("charger pin", {o_multipurpose_pin_twelve, o_multipurpose_pin_twelve_oe}, {c == 1, 1'b1});
            end
            i_usb_suspend = 1'b0;
            if (k == 0) tx_frames();
            if (k == 2) lamps_power();
            if (k > 2) irq_bus(k % 4);
        end
        report_and_stop();
    end
endmodule // uipc_pin_config_tb
